// file: pfh_pkg.sv
// Package for the parallel flash host controller: constants, types and timing
`default_nettype none
package pfh_pkg;
   // Bus widths
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;

   // Clock and timing (ns)
   localparam int CLK_PERIOD_NS       = 20;
   localparam int ACCESS_TIME_NS      = 90;   // Chip enable access time
   localparam int WRITE_PULSE_NS      = 40;   // Write enable low time
   localparam int RESET_PULSE_MIN_NS  = 500;  // Minimum reset pulse
   localparam int RESET_HIGH_TO_READ_NS = 50; // Reset high to first read
   localparam int ACCESS_CYC  = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYC   = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_CYC   = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RHTR_CYC    = (RESET_HIGH_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W       = 8;

   // Unlock addresses, word and byte mode
   localparam logic [ADDR_W-1:0] UNLOCK1_WORD = 18'h0_0555;
   localparam logic [ADDR_W-1:0] UNLOCK2_WORD = 18'h0_02AA;
   localparam logic [ADDR_W-1:0] UNLOCK1_BYTE = 18'h0_0AAA;
   localparam logic [ADDR_W-1:0] UNLOCK2_BYTE = 18'h0_0555;
   localparam logic [ADDR_W-1:0] ADDR_ZERO    = 18'h0_0000;
   localparam logic [ADDR_W-1:0] ID_MFR_ADDR  = 18'h0_0000;
   localparam logic [ADDR_W-1:0] ID_DEV_ADDR  = 18'h0_0001;
   localparam logic [ADDR_W-1:0] PROT_VFY_OFS = 18'h0_0002;

   // Command data codes
   localparam logic [DATA_W-1:0] CODE_AA      = 16'h00AA;
   localparam logic [DATA_W-1:0] CODE_55      = 16'h0055;
   localparam logic [DATA_W-1:0] CODE_IDENT   = 16'h0090;
   localparam logic [DATA_W-1:0] CODE_PROGRAM = 16'h00A0;
   localparam logic [DATA_W-1:0] CODE_ERASE_SETUP = 16'h0080;
   localparam logic [DATA_W-1:0] CODE_CHIP_ERASE  = 16'h0010;
   localparam logic [DATA_W-1:0] CODE_SECT_ERASE  = 16'h0030;
   localparam logic [DATA_W-1:0] CODE_SUSPEND = 16'h00B0;
   localparam logic [DATA_W-1:0] CODE_RESUME  = 16'h0030;
   localparam logic [DATA_W-1:0] CODE_RESET   = 16'h00F0;
   localparam logic [DATA_W-1:0] DATA_ZERO    = 16'h0000;

   // Host operations
   typedef enum logic [3:0] {
      OP_READ, OP_WRITE, OP_RESET_CMD, OP_IDENT, OP_READ_ID, OP_PROT_VERIFY,
      OP_PROGRAM, OP_FAST_PROGRAM, OP_CHIP_ERASE, OP_SECT_ERASE,
      OP_SUSPEND, OP_RESUME, OP_HW_RESET, OP_STANDBY
   } pfh_op_t;

   // One request from the user side
   typedef struct packed {
      pfh_op_t           op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pfh_req_t;

   // Pins toward the flash
   typedef struct packed {
      logic              chip_enable_n;
      logic              output_enable_n;
      logic              write_enable_n;
      logic              reset_n;
      logic              width_select;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data_out;
      logic              data_oe;
   } pfh_pins_t;

   // One bus step handed to the cycle engine
   typedef struct packed {
      logic              is_write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pfh_step_t;
endpackage : pfh_pkg
`default_nettype wire

// file: pfh_cycle.sv
// Single bus cycle engine: one read or one write on the flash pins
`default_nettype none
module pfh_cycle (
   input  wire logic               clock,
   input  wire logic               resetn,
   input  wire logic               start,
   input  wire pfh_pkg::pfh_step_t step,
   input  wire logic [15:0]        data_in,
   output logic                    chip_enable_n,
   output logic                    output_enable_n,
   output logic                    write_enable_n,
   output logic [17:0]             addr,
   output logic [15:0]             data_out,
   output logic                    data_oe,
   output logic [15:0]             rdata,
   output logic                    done
);
   typedef enum logic [1:0] {CY_IDLE, CY_ACT, CY_END} pfh_cy_t;

   // Whole state of the engine
   typedef struct packed {
      pfh_cy_t                         st;
      logic [pfh_pkg::CNT_W-1:0]       cnt;
      logic                            wr;
      logic                            ce_n;
      logic                            oe_n;
      logic                            we_n;
      logic [17:0]                     a;
      logic [15:0]                     d;
      logic                            doe;
      logic [15:0]                     rd;
      logic                            dn;
   } pfh_cy_state_t;

   pfh_cy_state_t s_r;   // Registered state
   pfh_cy_state_t s_nxt; // Next state

   // Next-state logic
   always_comb begin
      s_nxt    = s_r;
      s_nxt.dn = 1'b0;
      unique case (s_r.st)
         CY_IDLE: begin
            if (start) begin
               s_nxt.st   = CY_ACT;
               s_nxt.wr   = step.is_write;
               s_nxt.a    = step.addr;
               s_nxt.d    = step.data;
               s_nxt.ce_n = 1'b0;
               // Read keeps write enable high; write keeps output enable high
               s_nxt.oe_n = step.is_write;
               s_nxt.we_n = !step.is_write;
               s_nxt.doe  = step.is_write;       // Never drive while flash may drive
               s_nxt.cnt  = step.is_write ? pfh_pkg::CNT_W'(pfh_pkg::WRITE_CYC)
                                          : pfh_pkg::CNT_W'(pfh_pkg::ACCESS_CYC);
            end
         end
         CY_ACT: begin
            if (s_r.cnt > pfh_pkg::CNT_W'(1)) begin
               s_nxt.cnt = s_r.cnt - pfh_pkg::CNT_W'(1);
            end else begin
               // Sample read data after the full access time
               if (!s_r.wr) begin
                  s_nxt.rd = data_in;
               end
               s_nxt.oe_n = 1'b1;
               s_nxt.we_n = 1'b1;
               s_nxt.st   = CY_END;
            end
         end
         CY_END: begin
            // Hold data one cycle past the write edge, then release
            s_nxt.ce_n = 1'b1;
            s_nxt.doe  = 1'b0;
            s_nxt.dn   = 1'b1;
            s_nxt.st   = CY_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_r <= '{st: CY_IDLE, cnt: '0, wr: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  a: '0, d: '0, doe: 1'b0, rd: '0, dn: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign chip_enable_n   = s_r.ce_n;
   assign output_enable_n = s_r.oe_n;
   assign write_enable_n  = s_r.we_n;
   assign addr            = s_r.a;
   assign data_out        = s_r.d;
   assign data_oe         = s_r.doe;
   assign rdata           = s_r.rd;
   assign done            = s_r.dn;

   // Strobes never both low
   property p_no_contention;
      @(posedge clock) disable iff (!resetn) !(s_r.oe_n == 1'b0 && s_r.we_n == 1'b0);
   endproperty
   a_no_contention: assert property (p_no_contention) else $error("oe and we low together");

   // Host drives data only while output enable is high
   property p_drive_oe_high;
      @(posedge clock) disable iff (!resetn) s_r.doe |-> s_r.oe_n;
   endproperty
   a_drive_oe_high: assert property (p_drive_oe_high) else $error("driving data with oe low");
endmodule // pfh_cycle
`default_nettype wire

// file: pfh_host.sv
// Host controller that drives a parallel NOR flash through its pins
// Summary of operation
// - Read: CE, OE low, WE high
// - Write: CE, WE low, OE high
// - Host does not restart an operation interrupted by reset; the user reissues it
// - Wait reset-high-to-read before reading
// - Reset code aborts failure, then command
// - Unlock addresses differ by byte/word mode
// - Identifier mode held until reset command or hardware reset
`default_nettype none
module pfh_host (
   input  wire logic               clock,
   input  wire logic               resetn,
   input  wire pfh_pkg::pfh_req_t  req,
   input  wire logic               req_valid,
   input  wire logic               byte_mode,
   output logic                    req_ready,
   output logic [15:0]             rsp_data,
   output logic                    rsp_valid,
   output logic                    busy,
   output logic                    erasing,
   output logic                    in_ident,
   input  wire logic [15:0]        flash_data_in,
   input  wire logic               ready_busy_n,
   output pfh_pkg::pfh_pins_t      pins
);
   typedef enum logic [2:0] {
      H_IDLE, H_SEQ, H_WAIT, H_RST_LOW, H_RST_REC, H_BUSYWAIT
   } pfh_hst_t;

   // Whole state of the host
   typedef struct packed {
      pfh_hst_t                    st;
      pfh_pkg::pfh_op_t            op;
      logic [2:0]                  idx;    // Step index in the sequence
      logic [2:0]                  len;    // Steps in the sequence
      logic [17:0]                 addr;
      logic [15:0]                 data;
      logic [pfh_pkg::CNT_W-1:0]   cnt;
      logic                        rdy;
      logic [15:0]                 rsp;
      logic                        rv;
      logic                        erase_run;
      logic                        ident;
      logic                        rst_n;
      logic                        wsel;
      logic                        bypass;
      logic                        bsy;    // Registered busy flag for the user port
   } pfh_hst_state_t;

   pfh_hst_state_t s_r;   // Registered state
   pfh_hst_state_t s_nxt; // Next state

   pfh_pkg::pfh_step_t step;       // Current bus step
   logic               cy_start;   // Launch one bus cycle
   logic               cy_done;    // Bus cycle finished
   logic [15:0]        cy_rdata;   // Data of a read cycle
   logic [17:0]        u1;         // First unlock address for the width
   logic [17:0]        u2;         // Second unlock address for the width
   logic               cy_ce_n;
   logic               cy_oe_n;
   logic               cy_we_n;
   logic [17:0]        cy_addr;
   logic [15:0]        cy_dout;
   logic               cy_doe;

   // Unlock addresses follow the bus width
   assign u1 = s_r.wsel ? pfh_pkg::UNLOCK1_WORD : pfh_pkg::UNLOCK1_BYTE;
   assign u2 = s_r.wsel ? pfh_pkg::UNLOCK2_WORD : pfh_pkg::UNLOCK2_BYTE;

   // Build the bus step for the current index of the sequence
   always_comb begin
      step = '{is_write: 1'b1, addr: u1, data: pfh_pkg::CODE_AA};
      unique case (s_r.op)
         pfh_pkg::OP_READ, pfh_pkg::OP_READ_ID: begin
            step.is_write = 1'b0;
            step.addr     = s_r.addr;
         end
         pfh_pkg::OP_PROT_VERIFY: begin
            step.is_write = 1'b0;
            step.addr     = s_r.addr | pfh_pkg::PROT_VFY_OFS;
         end
         pfh_pkg::OP_WRITE: begin
            step.addr = s_r.addr;
            step.data = s_r.data;
         end
         pfh_pkg::OP_RESET_CMD, pfh_pkg::OP_SUSPEND, pfh_pkg::OP_RESUME: begin
            step.addr = pfh_pkg::ADDR_ZERO;
            step.data = (s_r.op == pfh_pkg::OP_SUSPEND) ? pfh_pkg::CODE_SUSPEND :
                        (s_r.op == pfh_pkg::OP_RESUME)  ? pfh_pkg::CODE_RESUME  :
                                                          pfh_pkg::CODE_RESET;
         end
         pfh_pkg::OP_FAST_PROGRAM: begin
            // Two writes only: program code, then address and data
            step.data = pfh_pkg::CODE_PROGRAM;
            if (s_r.idx == 3'd1) begin
               step.addr = s_r.addr;
               step.data = s_r.data;
            end
         end
         default: begin
            // Unlock pair, command, then optional second unlock and final code
            unique case (s_r.idx)
               3'd0: step.data = pfh_pkg::CODE_AA;
               3'd1: begin
                  step.addr = u2;
                  step.data = pfh_pkg::CODE_55;
               end
               3'd2: step.data = (s_r.op == pfh_pkg::OP_IDENT)   ? pfh_pkg::CODE_IDENT   :
                                 (s_r.op == pfh_pkg::OP_PROGRAM) ? pfh_pkg::CODE_PROGRAM :
                                                                   pfh_pkg::CODE_ERASE_SETUP;
               3'd3: begin
                  if (s_r.op == pfh_pkg::OP_PROGRAM) begin
                     step.addr = s_r.addr;
                     step.data = s_r.data;
                  end
               end
               3'd4: begin
                  step.addr = u2;
                  step.data = pfh_pkg::CODE_55;
               end
               default: begin
                  // Sector address on the high bits selects the sector
                  step.addr = (s_r.op == pfh_pkg::OP_SECT_ERASE) ? s_r.addr : u1;
                  step.data = (s_r.op == pfh_pkg::OP_SECT_ERASE) ? pfh_pkg::CODE_SECT_ERASE
                                                                 : pfh_pkg::CODE_CHIP_ERASE;
               end
            endcase
         end
      endcase
   end

   // Next-state logic of the host
   always_comb begin
      s_nxt    = s_r;
      s_nxt.rv = 1'b0;
      cy_start = 1'b0;
      unique case (s_r.st)
         H_IDLE: begin
            s_nxt.rdy = 1'b1;
            if (req_valid && s_r.rdy) begin
               s_nxt.rdy  = 1'b0;
               s_nxt.op   = req.op;
               s_nxt.addr = req.addr;
               s_nxt.data = req.data;
               s_nxt.idx  = 3'd0;
               s_nxt.wsel = !byte_mode;
               s_nxt.st   = H_SEQ;
               unique case (req.op)
                  pfh_pkg::OP_PROGRAM: s_nxt.len = 3'd4;
                  // Identifier entry is three writes; the codes come back on plain reads
                  pfh_pkg::OP_IDENT: s_nxt.len = 3'd3;
                  pfh_pkg::OP_CHIP_ERASE, pfh_pkg::OP_SECT_ERASE: s_nxt.len = 3'd6;
                  pfh_pkg::OP_FAST_PROGRAM: s_nxt.len = 3'd2;
                  pfh_pkg::OP_HW_RESET: s_nxt.st = H_RST_LOW;
                  pfh_pkg::OP_STANDBY: begin
                     // Chip stays deselected; nothing to drive
                     s_nxt.st = H_IDLE;
                     s_nxt.rv = 1'b1;
                  end
                  default: s_nxt.len = 3'd1;
               endcase
               // Only suspend/resume while an erase runs; program busy blocks all but hardware reset
               if ((req.op == pfh_pkg::OP_SUSPEND || req.op == pfh_pkg::OP_RESUME)
                   && !s_r.erase_run) begin
                  s_nxt.st = H_IDLE;
                  s_nxt.rv = 1'b1;
               end
               if (!ready_busy_n && s_r.erase_run == 1'b0 && req.op != pfh_pkg::OP_HW_RESET) begin
                  s_nxt.st = H_IDLE;
                  s_nxt.rv = 1'b1;
               end
               s_nxt.cnt = pfh_pkg::CNT_W'(pfh_pkg::RESET_CYC);
            end
         end
         H_SEQ: begin
            cy_start = 1'b1;
            s_nxt.st = H_WAIT;
         end
         H_WAIT: begin
            if (cy_done) begin
               s_nxt.rsp = cy_rdata;
               if (s_r.idx + 3'd1 < s_r.len) begin
                  s_nxt.idx = s_r.idx + 3'd1;
                  s_nxt.st  = H_SEQ;
               end else begin
                  s_nxt.rv = 1'b1;
                  s_nxt.st = H_IDLE;
                  unique case (s_r.op)
                     pfh_pkg::OP_IDENT:     s_nxt.ident = 1'b1;
                     pfh_pkg::OP_RESET_CMD: begin
                        s_nxt.ident     = 1'b0;
                        s_nxt.erase_run = 1'b0;
                     end
                     pfh_pkg::OP_CHIP_ERASE, pfh_pkg::OP_SECT_ERASE: begin
                        s_nxt.erase_run = 1'b1;
                        s_nxt.st        = H_BUSYWAIT;
                     end
                     pfh_pkg::OP_PROGRAM, pfh_pkg::OP_FAST_PROGRAM: s_nxt.st = H_BUSYWAIT;
                     default: ;
                  endcase
                  s_nxt.cnt = pfh_pkg::CNT_W'(pfh_pkg::RHTR_CYC);
               end
            end
         end
         H_BUSYWAIT: begin
            // Give the flash time to pull busy, then release the user
            if (s_r.cnt != '0) begin
               s_nxt.cnt = s_r.cnt - pfh_pkg::CNT_W'(1);
            end else begin
               s_nxt.st = H_IDLE;
            end
         end
         H_RST_LOW: begin
            // Hold reset low for the minimum pulse
            s_nxt.rst_n = 1'b0;
            if (s_r.cnt != '0) begin
               s_nxt.cnt = s_r.cnt - pfh_pkg::CNT_W'(1);
            end else begin
               s_nxt.rst_n     = 1'b1;
               s_nxt.ident     = 1'b0;
               s_nxt.erase_run = 1'b0;
               s_nxt.cnt       = pfh_pkg::CNT_W'(pfh_pkg::RHTR_CYC);
               s_nxt.st        = H_RST_REC;
            end
         end
         H_RST_REC: begin
            // Wait reset-high-to-read and for busy to release
            if (s_r.cnt != '0) begin
               s_nxt.cnt = s_r.cnt - pfh_pkg::CNT_W'(1);
            end else if (ready_busy_n) begin
               s_nxt.rv = 1'b1;
               s_nxt.st = H_IDLE;
            end
         end
      endcase
      // Erase ended once busy goes high outside suspend handling
      if (s_r.erase_run && ready_busy_n && s_r.st == H_IDLE && s_r.op != pfh_pkg::OP_SUSPEND) begin
         s_nxt.erase_run = 1'b0;
      end
      // Busy is kept in its own flop so the output needs no gate
      s_nxt.bsy = !s_nxt.rdy;
   end

   // State register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s_r <= '{st: H_IDLE, op: pfh_pkg::OP_READ, idx: '0, len: '0, addr: '0, data: '0,
                  cnt: '0, rdy: 1'b0, rsp: '0, rv: 1'b0, erase_run: 1'b0, ident: 1'b0,
                  rst_n: 1'b1, wsel: 1'b1, bypass: 1'b0, bsy: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   // Bus cycle engine
   pfh_cycle u_cycle (
      .clock           (clock),
      .resetn          (resetn),
      .start           (cy_start),
      .step            (step),
      .data_in         (flash_data_in),
      .chip_enable_n   (cy_ce_n),
      .output_enable_n (cy_oe_n),
      .write_enable_n  (cy_we_n),
      .addr            (cy_addr),
      .data_out        (cy_dout),
      .data_oe         (cy_doe),
      .rdata           (cy_rdata),
      .done            (cy_done)
   );

   // Pins come from engine flip-flops or host state flip-flops
   always_comb begin
      pins.chip_enable_n   = cy_ce_n;
      pins.output_enable_n = cy_oe_n;
      pins.write_enable_n  = cy_we_n;
      pins.reset_n         = s_r.rst_n;
      pins.width_select    = s_r.wsel;
      pins.addr            = cy_addr;
      pins.data_out        = cy_dout;
      pins.data_oe         = cy_doe;
   end

   assign req_ready = s_r.rdy;
   assign rsp_data  = s_r.rsp;
   assign rsp_valid = s_r.rv;
   assign busy      = s_r.bsy;
   assign erasing   = s_r.erase_run;
   assign in_ident  = s_r.ident;

   // No bus cycle starts while reset is driven low
   property p_no_access_in_reset;
      @(posedge clock) disable iff (!resetn) !s_r.rst_n |-> cy_ce_n;
   endproperty
   a_no_access_in_reset: assert property (p_no_access_in_reset) else $error("access during reset");

   // Reset pulse lasts at least eight cycles
   property p_reset_width;
      @(posedge clock) disable iff (!resetn) $fell(s_r.rst_n) |-> !s_r.rst_n [*8];
   endproperty
   a_reset_width: assert property (p_reset_width) else $error("reset pulse too short");

   // Identifier flag clears after reset command completes
   property p_ident_clear;
      @(posedge clock) disable iff (!resetn)
         (s_r.st == H_WAIT && cy_done && s_r.op == pfh_pkg::OP_RESET_CMD && s_r.idx + 3'd1 >= s_r.len)
         |=> !s_r.ident;
   endproperty
   a_ident_clear: assert property (p_ident_clear) else $error("ident not cleared");

   // Suspend or resume outside an erase is answered at once, with no bus cycle
   property p_refuse_suspend;
      @(posedge clock) disable iff (!resetn)
         (s_r.st == H_IDLE && s_r.rdy && req_valid && !s_r.erase_run
          && (req.op == pfh_pkg::OP_SUSPEND || req.op == pfh_pkg::OP_RESUME))
         |=> (s_r.st == H_IDLE && s_r.rv);
   endproperty
   a_refuse_suspend: assert property (p_refuse_suspend) else $error("suspend taken outside erase");
endmodule // pfh_host
`default_nettype wire

// file: pfh_flash_model.sv
// Behavioural word-mode flash that answers the host controller pins
`default_nettype none
module pfh_flash_model #(
   parameter logic [15:0] MFR_CODE = 16'h005A, // Arbitrary maker code
   parameter logic [15:0] DEV_CODE = 16'h00C3  // Arbitrary device code
) (
   input  wire pfh_pkg::pfh_pins_t pins,
   output logic [15:0]             flash_data_in,
   output logic                    ready_busy_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [0:255]; // Small array on the low address bits
   logic [2:0]  mode;        // 0 read, 1-2 unlock, 3 identifier, 4 program
   logic [15:0] dout;        // Value the outputs would show
   logic [15:0] last;        // Last driven value, inverted when released
   logic        drive;       // Outputs enabled
   logic [15:0] d;           // Written data
   assign d = pins.data_out;
   assign drive = !pins.chip_enable_n && !pins.output_enable_n && pins.write_enable_n && pins.reset_n;
   // Released bus shows the inverse so a stale value never passes
   assign flash_data_in = drive ? dout : ~last;
   initial begin
      ready_busy_n = 1'b1;
      mode = 3'd0;
      last = 16'h0000;
      for (int i = 0; i < 256; i++) mem[i] = 16'h3C00 + 16'(i);
   end
   // Read data: identifier codes or array contents
   always_comb begin
      if (mode != 3'd3) dout = mem[pins.addr[7:0]];
      else if (pins.addr[1]) dout = {15'h0000, pins.addr[17]};
      else dout = pins.addr[0] ? DEV_CODE : MFR_CODE;
   end
   always @(posedge drive) last = dout;
   // Hardware reset drops any sequence
   always @(negedge pins.reset_n) mode <= 3'd0;
   // Command decoder, latched at the end of the write strobe
   always @(posedge pins.write_enable_n) begin
      if (!pins.chip_enable_n && pins.output_enable_n && pins.reset_n) begin
         if (d == 16'h00F0 && mode != 3'd4) mode <= 3'd0;
         else case (mode)
            3'd0: mode <= (pins.addr[10:0] == 11'h555 && d == 16'h00AA) ? 3'd1 : 3'd0;
            3'd1: mode <= (pins.addr[10:0] == 11'h2AA && d == 16'h0055) ? 3'd2 : 3'd0;
            3'd2: mode <= (d == 16'h0090) ? 3'd3 : (d == 16'h00A0) ? 3'd4 : 3'd0;
            3'd3: mode <= 3'd3;
            default: begin
               mem[pins.addr[7:0]] = d;
               mode <= 3'd0;
               ready_busy_n <= 1'b0;
               ready_busy_n <= #200 1'b1;
            end
         endcase
      end
   end
endmodule // pfh_flash_model
`default_nettype wire

// file: tb.sv
// Self-checking testbench for the parallel flash host controller
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] MFR = 16'h005A; // Arbitrary maker code
   localparam logic [15:0] DEV = 16'h00C3; // Arbitrary device code
   logic clock, resetn, req_valid, byte_mode, req_ready, rsp_valid, busy, erasing, in_ident, ready_busy_n;
   logic [15:0] rsp_data, flash_data_in;
   pfh_pkg::pfh_req_t  req;
   pfh_pkg::pfh_pins_t pins;
   int num_errors, checked, writes;
   pfh_host dut (.clock(clock), .resetn(resetn), .req(req), .req_valid(req_valid), .byte_mode(byte_mode),
      .req_ready(req_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .busy(busy), .erasing(erasing),
      .in_ident(in_ident), .flash_data_in(flash_data_in), .ready_busy_n(ready_busy_n), .pins(pins));
   pfh_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash (.pins(pins), .flash_data_in(flash_data_in),
      .ready_busy_n(ready_busy_n));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Count write strobes seen on the pins
   always @(negedge pins.write_enable_n) writes++;
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // One request, held until taken, then wait for its answer
   task automatic do_op(pfh_pkg::pfh_op_t op, logic [17:0] a, logic [15:0] dt);
      int n;
      n = 0;
      req = '{op: op, addr: a, data: dt};
      req_valid = 1'b1;
      do @(posedge clock); while (req_ready !== 1'b1);
      #1 req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 400) begin
         @(posedge clock);
         #1 n++;
      end
      check("answer", 16'h0001, {15'h0000, rsp_valid});
      // Let an edge pass so the next request never shares this time step
      @(posedge clock);
      #1;
   endtask
   task automatic t_array();
      check("idle busy", 16'h0000, {15'h0000, busy});
      do_op(pfh_pkg::OP_READ, 18'h0_0003, 16'h0000);
      check("array 3", 16'h3C03, rsp_data);
      do_op(pfh_pkg::OP_STANDBY, 18'h0_0000, 16'h0000);
      check("standby ce", 16'h0001, {15'h0000, pins.chip_enable_n});
      do_op(pfh_pkg::OP_READ, 18'h0_00FE, 16'h0000);
      check("array FE", 16'h3CFE, rsp_data);
   endtask
   task automatic t_ident();
      int w;
      w = writes;
      do_op(pfh_pkg::OP_IDENT, 18'h0_0000, 16'h0000);
      check("ident writes", 16'h0003, 16'(writes - w));
      check("in_ident", 16'h0001, {15'h0000, in_ident});
      do_op(pfh_pkg::OP_READ_ID, 18'h0_0000, 16'h0000);
      check("maker", MFR, rsp_data);
      do_op(pfh_pkg::OP_READ_ID, 18'h0_0001, 16'h0000);
      check("device", DEV, rsp_data);
      do_op(pfh_pkg::OP_READ, 18'h0_0004, 16'h0000);
      check("held ident", MFR, rsp_data);
      do_op(pfh_pkg::OP_RESET_CMD, 18'h0_0000, 16'h0000);
      check("left ident", 16'h0000, {15'h0000, in_ident});
      do_op(pfh_pkg::OP_READ, 18'h0_0004, 16'h0000);
      check("array after reset", 16'h3C04, rsp_data);
   endtask
   task automatic t_protect();
      // Protection codes are only readable in identifier mode
      do_op(pfh_pkg::OP_IDENT, 18'h0_0000, 16'h0000);
      do_op(pfh_pkg::OP_PROT_VERIFY, 18'h2_0000, 16'h0000);
      check("protected", 16'h0001, rsp_data);
      do_op(pfh_pkg::OP_PROT_VERIFY, 18'h0_1000, 16'h0000);
      check("unprotected", 16'h0000, rsp_data);
      do_op(pfh_pkg::OP_RESET_CMD, 18'h0_0000, 16'h0000);
   endtask
   task automatic t_program();
      int w;
      w = writes;
      do_op(pfh_pkg::OP_SUSPEND, 18'h0_0000, 16'h0000);
      check("suspend refused", 16'h0000, 16'(writes - w));
      do_op(pfh_pkg::OP_PROGRAM, 18'h0_0009, 16'h1234);
      check("program writes", 16'h0004, 16'(writes - w));
      repeat (15) @(posedge clock);
      #1 do_op(pfh_pkg::OP_READ, 18'h0_0009, 16'h0000);
      check("programmed", 16'h1234, rsp_data);
      w = writes;
      do_op(pfh_pkg::OP_FAST_PROGRAM, 18'h0_000A, 16'h5678);
      check("fast writes", 16'h0002, 16'(writes - w));
      repeat (15) @(posedge clock);
      #1 do_op(pfh_pkg::OP_HW_RESET, 18'h0_0000, 16'h0000);
      do_op(pfh_pkg::OP_READ, 18'h0_0009, 16'h0000);
      check("read after hw reset", 16'h1234, rsp_data);
      do_op(pfh_pkg::OP_PROGRAM, 18'h0_000A, 16'h5678);
      repeat (15) @(posedge clock);
      #1 do_op(pfh_pkg::OP_READ, 18'h0_000A, 16'h0000);
      check("restarted program", 16'h5678, rsp_data);
      byte_mode = 1'b1;
      do_op(pfh_pkg::OP_RESET_CMD, 18'h0_0000, 16'h0000);
      check("byte width", 16'h0000, {15'h0000, pins.width_select});
      byte_mode = 1'b0;
   endtask
   task automatic t_erase();
      int w;
      w = writes;
      do_op(pfh_pkg::OP_SECT_ERASE, 18'h1_0000, 16'h0000);
      check("erase writes", 16'h0006, 16'(writes - w));
      check("erasing", 16'h0001, {15'h0000, erasing});
      repeat (10) @(posedge clock);
      #1 w = writes;
      do_op(pfh_pkg::OP_RESUME, 18'h0_0000, 16'h0000);
      check("resume refused", 16'h0000, 16'(writes - w));
   endtask
   task automatic stop_test();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      resetn = 1'b0;
      req_valid = 1'b0;
      byte_mode = 1'b0;
      req = '0;
      num_errors = 0;
      checked = 0;
      writes = 0;
      repeat (6) @(posedge clock);
      #1 resetn = 1'b1;
      repeat (2) @(posedge clock);
      #1 t_array();
      t_ident();
      t_protect();
      t_program();
      t_erase();
      stop_test();
   end
   // Watchdog well beyond the expected run of a few hundred cycles
   initial begin
      #200000;
      num_errors++;
      stop_test();
   end
endmodule // tb
`default_nettype wire
